// *** rtl/ifp_pkg.sv ***
package ifp_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    // The offset printed for the flag register (008A) is not a multiple
    // of four, so both offsets (008A, 00A4) are kept as indices and the byte address is 4x.
    localparam logic [15:0] IFP_FLAGS_THREE_INDEX = 16'h008a;
    localparam logic [15:0] IFP_PRIORITY_ZERO_INDEX = 16'h00a4;
    localparam logic [17:0] IFP_FLAGS_THREE_ADDR =
        {IFP_FLAGS_THREE_INDEX, 2'b00};
    localparam logic [17:0] IFP_PRIORITY_ZERO_ADDR =
        {IFP_PRIORITY_ZERO_INDEX, 2'b00};

    // ==========================================================
    // Field layout
    // ==========================================================
    localparam int IFP_REG_WIDTH = 16;
    localparam int IFP_CALENDAR_BIT = 14;
    localparam int IFP_PRIO_WIDTH = 3;
    localparam int IFP_PRIO_COUNT = 4;
    localparam int IFP_PRIO_STRIDE = 4;
    localparam logic [15:0] IFP_PRIORITY_MASK = 16'h7777;
    localparam logic [15:0] IFP_PRIORITY_RESET = 16'h4444;
    localparam logic [2:0] IFP_PRIO_DISABLED = 3'h0;

endpackage : ifp_pkg

// *** rtl/ifp_interrupt_flag_priority.sv ***
// Notes on behaviour
// - Calendar request sets flag bit 14 to one
// - Flag is software read/write, hardware set, resets zero
// - Other flag register bits read as zero
// - Four 3-bit priority fields at fixed positions
// - Priority code seven highest, zero disables source
// - Priority fields reset to four
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module ifp_interrupt_flag_priority
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt sources.
    input wire logic calendar_request,
    // Flag and priorities toward the core.
    output logic calendar_request_flag,
    output logic [2:0] timer_one_priority,
    output logic [2:0] compare_one_priority,
    output logic [2:0] capture_one_priority,
    output logic [2:0] external_zero_priority,
    output logic [3:0] source_enabled
);

    // ==========================================================
    // Bus decode
    // ==========================================================
    logic access;
    logic hit_flags;
    logic hit_prio;
    logic [15:0] lane_mask;
    logic [15:0] source_priority_zero;
    logic [15:0] next_priority;
    logic [15:0] read_value;

    assign access = psel && penable && pready;
    assign hit_flags = paddr[17:0] == ifp_pkg::IFP_FLAGS_THREE_ADDR
        && paddr[31:18] == 14'h0000;
    assign hit_prio = paddr[17:0] == ifp_pkg::IFP_PRIORITY_ZERO_ADDR
        && paddr[31:18] == 14'h0000;
    assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // Zero-wait slave: pready is low in reset and high from the first edge after it, so every access ends at the
    // first access-phase edge.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= 1'b1;
    end

    // ==========================================================
    // Calendar request flag
    // ==========================================================
    // A request in the same cycle as a software clear wins, so no event
    // is lost.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            calendar_request_flag <= 1'b0;
        else if (calendar_request)
            calendar_request_flag <= 1'b1;
        else if (access && pwrite && hit_flags && pstrb[1])
            calendar_request_flag <=
                pwdata[ifp_pkg::IFP_CALENDAR_BIT];
    end

    // ==========================================================
    // Priority register
    // ==========================================================
    assign next_priority = ((source_priority_zero & ~lane_mask)
        | (pwdata[15:0] & lane_mask)) & ifp_pkg::IFP_PRIORITY_MASK;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            source_priority_zero <= ifp_pkg::IFP_PRIORITY_RESET;
        else if (access && pwrite && hit_prio)
            source_priority_zero <= next_priority;
    end

    // Field outputs are registered copies so each output is a flop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer_one_priority <= ifp_pkg::IFP_PRIORITY_RESET[14:12];
            compare_one_priority <= ifp_pkg::IFP_PRIORITY_RESET[10:8];
            capture_one_priority <= ifp_pkg::IFP_PRIORITY_RESET[6:4];
            external_zero_priority <= ifp_pkg::IFP_PRIORITY_RESET[2:0];
        end
        else
        begin
            timer_one_priority <= source_priority_zero[14:12];
            compare_one_priority <= source_priority_zero[10:8];
            capture_one_priority <= source_priority_zero[6:4];
            external_zero_priority <= source_priority_zero[2:0];
        end
    end

    // Bit i flags source i (0 external, 1 capture, 2 compare, 3 timer).
    genvar gi;
    generate
        for (gi = 0; gi < ifp_pkg::IFP_PRIO_COUNT; gi++)
        begin : g_enable
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    source_enabled[gi] <= 1'b1;
                else
                    source_enabled[gi] <= source_priority_zero[
                        gi * ifp_pkg::IFP_PRIO_STRIDE +:
                        ifp_pkg::IFP_PRIO_WIDTH]
                        != ifp_pkg::IFP_PRIO_DISABLED;
            end
        end
    endgenerate

    // ==========================================================
    // Read path
    // ==========================================================
    always_comb
    begin
        read_value = 16'h0000;
        if (hit_flags)
            read_value[ifp_pkg::IFP_CALENDAR_BIT] =
                calendar_request_flag;
        else if (hit_prio)
            read_value = source_priority_zero;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            if (psel && !penable)
            begin
                prdata <= {16'h0000, read_value};
                pslverr <= !(hit_flags || hit_prio);
            end
        end
    end

endmodule : ifp_interrupt_flag_priority

`default_nettype wire

// *** tb/ifp_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module ifp_monitor (
    input wire logic pclk, presetn, psel, penable, pwrite, pready,
    input wire logic [31:0] paddr, pwdata, prdata,
    input wire logic [3:0] pstrb, source_enabled,
    input wire logic calendar_request, calendar_request_flag,
    input wire logic [2:0] timer_one_priority, compare_one_priority,
    input wire logic [2:0] capture_one_priority, external_zero_priority
);
    // ==========
    // Checks.
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic rd = psel && penable && !pwrite;
    wire logic wr = psel && penable && pwrite && pready;
    property p_set; calendar_request |=> calendar_request_flag; endproperty
    a_set: assert property (p_set) else $error("flag not set");
    // A set outranks a clear, so only a write may drop the flag.
    property p_hold; calendar_request_flag && !(wr && paddr == 32'h228)
        |=> calendar_request_flag; endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
    property p_frd; rd && paddr == 32'h228 |-> (prdata & ~32'h4000) == 0;
    endproperty
    a_frd: assert property (p_frd) else $error("flag bits");
    property p_fld; wr && pstrb == 4'hf && paddr == 32'h290 |-> ##2
        timer_one_priority == $past(pwdata[14:12], 2) &&
        external_zero_priority == $past(pwdata[2:0], 2); endproperty
    a_fld: assert property (p_fld) else $error("field place");
    property p_en; source_enabled == {|timer_one_priority,
        |compare_one_priority, |capture_one_priority,
        |external_zero_priority}; endproperty
    a_en: assert property (p_en) else $error("enable code");
    property p_rst; $rose(presetn) |-> !calendar_request_flag &&
        timer_one_priority == 3'h4 && capture_one_priority == 3'h4;
    endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    property p_gap; rd && paddr == 32'h290 |-> (prdata & ~32'h7777) == 0;
    endproperty
    a_gap: assert property (p_gap) else $error("gap bits");
    c_clr: cover property (calendar_request_flag && wr && paddr == 32'h228);
    c_pri: cover property (wr && paddr == 32'h290);
    c_off: cover property (source_enabled != 4'hf);
endmodule : ifp_monitor
`default_nettype wire

// *** tb/ifp_calendar_source.sv ***
`timescale 1ns/1ps
`default_nettype none
// Calendar source: one request cycle for each cycle the bench fires.
module ifp_calendar_source (
    input wire logic pclk,
    input wire logic fire,
    output logic calendar_request
);
    always_ff @(posedge pclk)
    begin
        calendar_request <= fire;
    end
endmodule : ifp_calendar_source
`default_nettype wire

// *** tb/tb_interrupt_flag_priority.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_flag_priority;
    logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
    logic fire = '0, pready, pslverr, calendar_request, calendar_request_flag;
    logic [31:0] paddr = '0, pwdata = '0, prdata, r;
    logic [3:0] pstrb = 4'hf, source_enabled;
    logic [2:0] timer_one_priority, compare_one_priority;
    logic [2:0] capture_one_priority, external_zero_priority;
    logic e;
    int n_errors = 0, checks = 0;
    // Rows: address, written word, word read back.
    logic [31:0] rows [4][3] = '{'{32'h290, 32'hffffffff, 32'h7777},
        '{32'h290, 32'h1234, 32'h1234}, '{32'h228, 32'hffffffff, 32'h4000},
        '{32'h228, 32'h0, 32'h0}};
    always #12.5 pclk = ~pclk;
    ifp_interrupt_flag_priority dut (.*);
    ifp_calendar_source src (.*);
    task automatic chk(input logic [31:0] got, exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // One idle edge before each setup keeps a driver from two writes at once.
    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    initial
    begin
        repeat (3000) @(posedge pclk);
        n_errors++;
        give_verdict;
    end
    // ==========
    // Sequence.
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 32'h290, 0);
        chk(r, 32'h4444);
        chk({timer_one_priority, external_zero_priority}, 6'h24);
        apb(0, 32'h228, 0);
        chk(r, 32'h0);
        foreach (rows[i])
        begin
            apb(1, rows[i][0], rows[i][1]);
            apb(0, rows[i][0], 0);
            chk(r, rows[i][2]);
        end
        apb(1, 32'h290, 32'h7010);
        repeat (2) @(posedge pclk);
        chk({timer_one_priority, compare_one_priority, capture_one_priority,
            external_zero_priority, source_enabled}, 16'he08a);
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
        apb(0, 32'h228, 0);
        chk(r, 32'h4000);
        apb(0, 32'h300, 0);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 32'h290, 0);
        chk(r, 32'h4444);
        apb(0, 32'h228, 0);
        chk(r, 32'h0);
        give_verdict;
    end
endmodule : tb_interrupt_flag_priority
bind ifp_interrupt_flag_priority ifp_monitor mon (.*);
`default_nettype wire
